//--- design/dpc_pkg.sv
// constants, register map and carrier types for the disk port config block
package dpc_pkg;
    // register offsets on the processor port
    localparam logic [7:0] OFF_CONF2     = 8'h12;
    localparam logic [7:0] OFF_X_DIR     = 8'h14;
    localparam logic [7:0] OFF_X_DATA    = 8'h16;
    localparam logic [7:0] OFF_Y_CONF    = 8'h18;
    localparam logic [7:0] OFF_Y_DATA    = 8'h1a;
    localparam logic [7:0] OFF_SEQ_FLAGS = 8'h1c;
    localparam logic [7:0] OFF_ERR_FLAGS = 8'h1e;
    localparam logic [7:0] OFF_CONF1     = 8'h10;
    // configuration 2 fields, plus the soft reset bit of configuration 1
    localparam int B_COUNT_WIDTH = 7;
    localparam int B_BLOCK_ADDR  = 6;
    localparam int B_SEGMENTED   = 4;
    localparam int B_WRAP_FAIL   = 1;
    localparam int B_SOFT_RESET  = 0;
    // port y config fields
    localparam int B_EVEN_PAR = 7;
    localparam int B_AM_SYNC  = 6;
    localparam int B_IX_SYNC  = 5;
    localparam int B_SM_SYNC  = 4;
    localparam int Y_WIDTH    = 4;
    // sequencer flag positions
    localparam int F_ID_CAPT = 6;
    localparam int F_XFER    = 5;
    localparam int F_SEEK    = 4;
    localparam int F_STOP    = 3;
    localparam int F_INDEX   = 2;
    localparam int F_SECTOR  = 1;
    localparam logic [7:0] SEQ_FLAG_MASK = 8'h7e;
    // disk error flag positions
    localparam int E_WRAP = 4;
    // id layout widths and the register reset byte
    localparam logic [4:0] COUNT_BITS_3 = 5'h18;
    localparam logic [4:0] COUNT_BITS_4 = 5'h1e;
    localparam logic [2:0] COUNT_BYTES_3 = 3'h3;
    localparam logic [2:0] COUNT_BYTES_4 = 3'h4;
    localparam logic [7:0] RESET_BYTE = 8'h00;

    // sequencer side events
    typedef struct packed {
        logic id_captured;
        logic no_transfer;
        logic buffer_phase;
        logic stop_word;
        logic fail_active;
        logic active;
        logic [7:0] err_cond;
    } dpc_seq_t;

    // gate pins toward the drive
    typedef struct packed {
        logic write_gate;
        logic read_gate;
        logic sequence_flag;
        logic address_mark_enable;
    } dpc_gates_t;
endpackage

//--- design/dpc_top.sv
// register group, general ports, mark inputs and flags of the disk port
`timescale 1ns/100ps
`default_nettype none
module dpc_top #(
    parameter int X_WIDTH = 8
) (
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 rst_b,
    // processor register port
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    input  wire logic [7:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    output logic      [7:0]           reg_rdata,
    // general purpose ports
    input  wire logic [X_WIDTH-1:0]   port_x_in,
    output logic      [X_WIDTH-1:0]   port_x_out,
    output logic      [X_WIDTH-1:0]   port_x_oe,
    input  wire logic [3:0]           port_y_in,
    output logic      [3:0]           port_y_out,
    output logic      [3:0]           port_y_oe,
    // disk mark and control inputs
    input  wire logic                 address_mark_detect_in,
    input  wire logic                 index_detect_in,
    input  wire logic                 sector_mark_detect_in,
    input  wire logic                 seek_complete_in,
    input  wire logic                 track_end_in,
    // sequencer core side
    input  wire dpc_pkg::dpc_seq_t    seq_in,
    input  wire dpc_pkg::dpc_gates_t  gates_in,
    output dpc_pkg::dpc_gates_t       gates_out,
    output logic                      seq_abort,
    output logic      [2:0]           marks_to_seq,
    // id layout and disk data parity
    output logic                      id_block_mode,
    output logic      [4:0]           id_count_bits,
    output logic      [2:0]           id_count_bytes,
    output logic                      id_segmented,
    input  wire logic                 buf_par_in,
    input  wire logic                 disk_par_in,
    input  wire logic                 data_odd_in,
    output logic                      disk_par_out,
    output logic                      buf_par_out,
    output logic                      disk_par_error,
    // interrupt summary bits
    output logic                      summary_seq,
    output logic                      summary_err
);

    ////////////////////////////////////////////////////////////////////////
    // registers

    logic [7:0]         conf2;
    logic [X_WIDTH-1:0] x_dir;
    logic [X_WIDTH-1:0] x_data;
    logic [7:0]         y_conf;
    logic [3:0]         y_data;
    logic [7:0]         seq_flags;
    logic [7:0]         err_flags;
    logic               soft_reset;

    logic wr_conf1;
    logic wr_conf2;
    logic wr_xdir;
    logic wr_xdat;
    logic wr_yconf;
    logic wr_ydat;
    logic wr_seq;
    logic wr_err;
    assign wr_conf1 = reg_wr && reg_addr == dpc_pkg::OFF_CONF1;
    assign wr_conf2 = reg_wr && reg_addr == dpc_pkg::OFF_CONF2;
    assign wr_xdir  = reg_wr && reg_addr == dpc_pkg::OFF_X_DIR;
    assign wr_xdat  = reg_wr && reg_addr == dpc_pkg::OFF_X_DATA;
    assign wr_yconf = reg_wr && reg_addr == dpc_pkg::OFF_Y_CONF;
    assign wr_ydat  = reg_wr && reg_addr == dpc_pkg::OFF_Y_DATA;
    assign wr_seq   = reg_wr && reg_addr == dpc_pkg::OFF_SEQ_FLAGS;
    assign wr_err   = reg_wr && reg_addr == dpc_pkg::OFF_ERR_FLAGS;

    // soft reset bit, held while set; clears flags, never the ports
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            soft_reset <= 1'b0;
        else if (wr_conf1)
            soft_reset <= reg_wdata[dpc_pkg::B_SOFT_RESET];
    end

    // configuration 2
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            conf2 <= dpc_pkg::RESET_BYTE;
        else if (wr_conf2)
            conf2 <= reg_wdata;
    end

    // port registers; soft reset deliberately absent here
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            x_dir  <= '0;
            x_data <= '0;
            y_conf <= dpc_pkg::RESET_BYTE;
            y_data <= '0;
        end
        else
        begin
            if (wr_xdir)
                x_dir <= reg_wdata[X_WIDTH-1:0];
            if (wr_xdat)
                x_data <= reg_wdata[X_WIDTH-1:0];
            if (wr_yconf)
                y_conf <= reg_wdata;
            if (wr_ydat)
                y_data <= reg_wdata[3:0]; // upper bits dropped
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pins of the general ports

    // direction bit set drives the stored data
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            port_x_out <= '0;
            port_x_oe  <= '0;
            port_y_out <= '0;
            port_y_oe  <= '0;
        end
        else
        begin
            port_x_out <= x_data;
            port_x_oe  <= x_dir;
            port_y_out <= y_data;
            port_y_oe  <= y_conf[dpc_pkg::Y_WIDTH-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // id layout controls

    // block count or chs layout, count width, segmented format
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            id_block_mode  <= 1'b0;
            id_count_bits  <= dpc_pkg::COUNT_BITS_3;
            id_count_bytes <= dpc_pkg::COUNT_BYTES_3;
            id_segmented   <= 1'b0;
        end
        else
        begin
            id_block_mode  <= conf2[dpc_pkg::B_BLOCK_ADDR];
            id_count_bits  <= conf2[dpc_pkg::B_COUNT_WIDTH] ? dpc_pkg::COUNT_BITS_4
                                                            : dpc_pkg::COUNT_BITS_3;
            id_count_bytes <= conf2[dpc_pkg::B_COUNT_WIDTH] ? dpc_pkg::COUNT_BYTES_4
                                                            : dpc_pkg::COUNT_BYTES_3;
            id_segmented   <= conf2[dpc_pkg::B_SEGMENTED];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // disk port parity

    // even mode inverts the odd parity bit both ways and checks input
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            disk_par_out   <= 1'b0;
            buf_par_out    <= 1'b0;
            disk_par_error <= 1'b0;
        end
        else
        begin
            disk_par_out <= buf_par_in ^ y_conf[dpc_pkg::B_EVEN_PAR];
            buf_par_out  <= disk_par_in ^ y_conf[dpc_pkg::B_EVEN_PAR];
            // data_odd_in is xor of data bits; total must match selected parity
            disk_par_error <= (data_odd_in ^ disk_par_in) == y_conf[dpc_pkg::B_EVEN_PAR];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // mark inputs: direct or two-stage synchroniser

    logic [2:0] mark_raw;
    logic [2:0] mark_meta;
    logic [2:0] mark_sync;
    logic [2:0] mark_prev;
    logic [2:0] sync_sel;
    assign mark_raw = {address_mark_detect_in, index_detect_in, sector_mark_detect_in};
    assign sync_sel = {y_conf[dpc_pkg::B_AM_SYNC], y_conf[dpc_pkg::B_IX_SYNC],
                       y_conf[dpc_pkg::B_SM_SYNC]};

    // the first stage feeds only the second
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mark_meta <= '0;
            mark_sync <= '0;
        end
        else
        begin
            mark_meta <= mark_raw;
            mark_sync <= mark_meta;
        end
    end

    // per-mark selection of the path the sequencer sees
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_mark
            always_ff @(posedge ref_clk or negedge rst_b)
            begin
                if (!rst_b)
                    marks_to_seq[gi] <= 1'b0;
                else
                    marks_to_seq[gi] <= sync_sel[gi] ? mark_raw[gi]
                                                     : mark_sync[gi];
            end
        end
    endgenerate

    // previous mark levels for edge detection on the selected path
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            mark_prev <= '0;
        else
            mark_prev <= marks_to_seq;
    end

    ////////////////////////////////////////////////////////////////////////
    // abort and gates

    logic wrap_fail;
    logic err_fail;
    logic next_abort;
    // wrap only counts when enabled and fail bit active
    assign wrap_fail  = conf2[dpc_pkg::B_WRAP_FAIL] && track_end_in && seq_in.fail_active;
    assign err_fail   = seq_in.fail_active && (|seq_in.err_cond);
    assign next_abort = wrap_fail || (err_fail && seq_in.active);

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            seq_abort <= 1'b0;
        else
            seq_abort <= next_abort;
    end

    // gates forced low on the abort edge and while it is shown
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            gates_out <= '0;
        else if (next_abort || seq_abort)
            gates_out <= '0;
        else
            gates_out <= gates_in;
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer event flags

    logic       seek_prev;
    logic [1:0] xfer_prev;
    logic [7:0] seq_set;
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            seek_prev <= 1'b0;
            xfer_prev <= '0;
        end
        else
        begin
            seek_prev <= seek_complete_in;
            // each bit tracked alone so a rise under the other still counts
            xfer_prev <= {seq_in.buffer_phase, seq_in.no_transfer};
        end
    end

    // event set terms per flag position
    always_comb
    begin
        seq_set = '0;
        seq_set[dpc_pkg::F_ID_CAPT] = seq_in.id_captured;
        seq_set[dpc_pkg::F_XFER]    = (seq_in.no_transfer && !xfer_prev[0])
                                      || (seq_in.buffer_phase && !xfer_prev[1]);
        seq_set[dpc_pkg::F_SEEK]    = seek_complete_in && !seek_prev;
        seq_set[dpc_pkg::F_STOP]    = seq_in.stop_word || next_abort;
        seq_set[dpc_pkg::F_INDEX]   = seq_in.active && marks_to_seq[1]
                                      && !mark_prev[1];
        seq_set[dpc_pkg::F_SECTOR]  = seq_in.active && marks_to_seq[0]
                                      && !mark_prev[0];
    end

    // set wins over a written one in the same cycle
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            seq_flags <= '0;
        else if (soft_reset)
            seq_flags <= '0;
        else
            seq_flags <= ((seq_flags & ~(wr_seq ? reg_wdata : 8'h00)) | seq_set)
                         & dpc_pkg::SEQ_FLAG_MASK;
    end

    ////////////////////////////////////////////////////////////////////////
    // disk error flags

    logic [7:0] err_set;
    // conditions gated by the fail bit, wrap also by its enable
    always_comb
    begin
        err_set = seq_in.fail_active ? seq_in.err_cond : 8'h00;
        err_set[dpc_pkg::E_WRAP] = wrap_fail;
    end

    // write one clears, set wins, soft reset clears
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            err_flags <= '0;
        else if (soft_reset)
            err_flags <= '0;
        else
            err_flags <= (err_flags & ~(wr_err ? reg_wdata : 8'h00)) | err_set;
    end

    ////////////////////////////////////////////////////////////////////////
    // summary bits

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            summary_seq <= 1'b0;
            summary_err <= 1'b0;
        end
        else
        begin
            summary_seq <= |seq_flags;
            summary_err <= |err_flags;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data, pins for input bits, registers for output bits

    logic [7:0] next_rdata;
    always_comb
    begin
        next_rdata = 8'h00;
        case (reg_addr)
            dpc_pkg::OFF_CONF1:     next_rdata = {7'h00, soft_reset};
            dpc_pkg::OFF_CONF2:     next_rdata = conf2;
            dpc_pkg::OFF_X_DIR:     next_rdata = 8'(x_dir);
            dpc_pkg::OFF_X_DATA:    next_rdata = 8'((x_dir & x_data) | (~x_dir & port_x_in));
            dpc_pkg::OFF_Y_CONF:    next_rdata = y_conf;
            dpc_pkg::OFF_Y_DATA:    next_rdata = {4'h0, (y_conf[3:0] & y_data)
                                                  | (~y_conf[3:0] & port_y_in)};
            dpc_pkg::OFF_SEQ_FLAGS: next_rdata = seq_flags;
            dpc_pkg::OFF_ERR_FLAGS: next_rdata = err_flags;
            default:                next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            reg_rdata <= 8'h00;
        else if (reg_rd)
            reg_rdata <= next_rdata;
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    sequence s_abort_seen;
        next_abort;
    endsequence

    chk_abort_gates: assert property (@(posedge ref_clk) disable iff (!rst_b)
        s_abort_seen |=> gates_out == '0)
        else $error("gates not dropped on abort");

    chk_wrap_disabled: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !conf2[dpc_pkg::B_WRAP_FAIL] && !err_flags[dpc_pkg::E_WRAP]
        |=> !err_flags[dpc_pkg::E_WRAP])
        else $error("wrap handled while disabled");

    chk_wrap_flags: assert property (@(posedge ref_clk) disable iff (!rst_b)
        wrap_fail && !soft_reset |=> err_flags[dpc_pkg::E_WRAP] && seq_flags[dpc_pkg::F_STOP])
        else $error("wrap did not raise both flags");

    chk_port_keep: assert property (@(posedge ref_clk) disable iff (!rst_b)
        soft_reset && !wr_xdir && !wr_xdat |=> $stable(x_dir) && $stable(x_data))
        else $error("port changed by soft reset");

    chk_x_pin_drive: assert property (@(posedge ref_clk) disable iff (!rst_b)
        1'b1 |=> port_x_oe == $past(x_dir) && port_y_oe == $past(y_conf[3:0]))
        else $error("direction not applied");

    chk_seek_edge: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !seek_complete_in ##1 seek_complete_in && !soft_reset
        |=> seq_flags[dpc_pkg::F_SEEK])
        else $error("seek flag missed");

    chk_seq_clear: assert property (@(posedge ref_clk) disable iff (!rst_b)
        soft_reset |=> seq_flags == 8'h00 && err_flags == 8'h00)
        else $error("soft reset left flags");

    chk_seq_summary: assert property (@(posedge ref_clk) disable iff (!rst_b)
        |seq_flags |=> summary_seq)
        else $error("summary bit 0 missing");

    chk_err_gated: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !seq_in.fail_active && !soft_reset && !wr_err |=> err_flags == $past(err_flags))
        else $error("error flag without fail bit");

    chk_mark_async: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !sync_sel[1] [*3] |-> marks_to_seq[1] == $past(index_detect_in, 3))
        else $error("async mark delay wrong");

    chk_reserved_zero: assert property (@(posedge ref_clk) disable iff (!rst_b)
        seq_flags[7] == 1'b0 && seq_flags[0] == 1'b0)
        else $error("reserved flag bit set");

endmodule // dpc_top
`default_nettype wire

//--- verification/dpc_far_pins.sv
// far side model: levels on the two general purpose port pins
`timescale 1ns/100ps
`default_nettype none
module dpc_far_pins (
    // pins from the block
    input  wire logic [7:0] port_x_out,
    input  wire logic [7:0] port_x_oe,
    input  wire logic [3:0] port_y_out,
    input  wire logic [3:0] port_y_oe,
    // levels the drive side holds on pins it owns
    input  wire logic [7:0] x_far,
    input  wire logic [3:0] y_far,
    // resolved pin levels fed back to the block
    output logic      [7:0] port_x_in,
    output logic      [3:0] port_y_in
);
    // block wins where it drives, so a pin never reads a stale level
    assign port_x_in = (port_x_oe & port_x_out) | (~port_x_oe & x_far);
    assign port_y_in = (port_y_oe & port_y_out) | (~port_y_oe & y_far);
endmodule // dpc_far_pins
`default_nettype wire

//--- verification/tb_top.sv
// self-checking bench for the disk port config and status block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic                reg_wr = 1'b0;
    logic                reg_rd = 1'b0;
    logic                ref_clk = 1'b0;
    logic                rst_b = 1'b0;
    logic [7:0]          reg_addr = 8'h00;
    logic [7:0]          reg_wdata = 8'h00;
    logic [7:0]          x_far = 8'h00;
    logic [3:0]          y_far = 4'h0;
    logic [2:0]          mk = 3'h0;
    logic                seek_complete_in = 1'b0;
    logic                track_end_in = 1'b0;
    logic                buf_par_in = 1'b0;
    logic                disk_par_in = 1'b0;
    logic                data_odd_in = 1'b0;
    dpc_pkg::dpc_seq_t   seq_in = '0;
    dpc_pkg::dpc_gates_t gates_in = '0;
    dpc_pkg::dpc_gates_t gates_out;
    logic [7:0]          reg_rdata, port_x_in, port_x_out, port_x_oe;
    logic [3:0]          port_y_in, port_y_out, port_y_oe;
    logic [2:0]          marks_to_seq, id_count_bytes;
    logic [4:0]          id_count_bits;
    logic                seq_abort, id_block_mode, id_segmented, summary_seq, summary_err;
    logic                disk_par_out, buf_par_out, disk_par_error;
    int                  err_total = 0;
    int                  checked = 0;

    ////////////////////////////////////////////////////////////////////////////
    // design, far side pins, clock
    dpc_top dut (
        .ref_clk, .rst_b, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .port_x_in, .port_x_out, .port_x_oe, .port_y_in, .port_y_out, .port_y_oe,
        .address_mark_detect_in(mk[2]), .index_detect_in(mk[1]),
        .sector_mark_detect_in(mk[0]), .seek_complete_in, .track_end_in,
        .seq_in, .gates_in, .gates_out, .seq_abort, .marks_to_seq,
        .id_block_mode, .id_count_bits, .id_count_bytes, .id_segmented,
        .buf_par_in, .disk_par_in, .data_odd_in, .disk_par_out, .buf_par_out,
        .disk_par_error, .summary_seq, .summary_err
    );
    dpc_far_pins far (.port_x_out, .port_x_oe, .port_y_out, .port_y_oe, .x_far, .y_far,
        .port_x_in, .port_y_in);
    always #5 ref_clk = ~ref_clk;

    ////////////////////////////////////////////////////////////////////////////
    // shared helpers; all driving happens at the falling edge
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge ref_clk);
        reg_wr = 1'b0;
    endtask
    // read data is registered, so it is looked at one edge after the strobe
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(negedge ref_clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge ref_clk);
        reg_rd = 1'b0;
        chk(what, reg_rdata, exp);
    endtask
    // cycles from a mark going high until the sequencer sees it
    task automatic lat(input int i, input logic [7:0] exp);
        int n;
        n = 0;
        mk[i] = 1'b1;
        while (marks_to_seq[i] !== 1'b1 && n < 8)
        begin
            @(negedge ref_clk);
            n++;
        end
        chk("mark delay", n[7:0], exp);
        mk[i] = 1'b0;
        idle(5);
        if (n == 8)
            wrap_up();
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_conf;
        chk("count bits", {3'h0, id_count_bits}, 8'h18);
        wr(8'h12, 8'hd2);
        idle(2);
        chk("block mode", {7'h0, id_block_mode}, 8'h01);
        chk("count bits", {3'h0, id_count_bits}, 8'h1e);
        chk("count bytes", {5'h0, id_count_bytes}, 8'h04);
        chk("segmented", {7'h0, id_segmented}, 8'h01);
        wr(8'h12, 8'h00);
        idle(2);
        chk("block mode", {7'h0, id_block_mode}, 8'h00);
        chk("count bytes", {5'h0, id_count_bytes}, 8'h03);
    endtask
    // mixed directions on both ports, then soft reset must leave them alone
    task automatic t_ports;
        x_far = 8'h3c;
        wr(8'h14, 8'hf0);
        wr(8'h16, 8'ha5);
        wr(8'h18, 8'h0a);
        wr(8'h1a, 8'hfa);
        idle(2);
        chk("x oe", port_x_oe, 8'hf0);
        chk("x drive", port_x_out & port_x_oe, 8'ha0);
        chk("y oe", {4'h0, port_y_oe}, 8'h0a);
        chk("y drive", {4'h0, port_y_out & port_y_oe}, 8'h0a);
        rdc(8'h16, 8'hac, "x data");
        rdc(8'h1a, 8'h0a, "y data");
        wr(8'h10, 8'h01);
        wr(8'h10, 8'h00);
        rdc(8'h14, 8'hf0, "x dir");
        rdc(8'h16, 8'hac, "x data");
        rdc(8'h18, 8'h0a, "y conf");
    endtask
    task automatic t_events;
        seek_complete_in = 1'b1;
        idle(3);
        rdc(8'h1c, 8'h10, "seek flag");
        chk("seq summary", {7'h0, summary_seq}, 8'h01);
        wr(8'h1c, 8'hef);
        rdc(8'h1c, 8'h10, "seq flags");
        wr(8'h1c, 8'h10);
        idle(2);
        rdc(8'h1c, 8'h00, "seq flags");
        chk("seq summary", {7'h0, summary_seq}, 8'h00);
        seq_in.no_transfer = 1'b1;
        idle(3);
        rdc(8'h1c, 8'h20, "xfer flag");
        seq_in.id_captured = 1'b1;
        idle(1);
        seq_in.id_captured = 1'b0;
        seq_in.stop_word = 1'b1;
        idle(1);
        seq_in.stop_word = 1'b0;
        idle(3);
        rdc(8'h1c, 8'h68, "seq flags");
        wr(8'h10, 8'h01);
        wr(8'h10, 8'h00);
        rdc(8'h1c, 8'h00, "seq flags");
        seq_in.buffer_phase = 1'b1;
        idle(3);
        rdc(8'h1c, 8'h20, "xfer flag");
        wr(8'h1c, 8'h20);
        seq_in = '0;
        seek_complete_in = 1'b0;
    endtask
    // every mark in both synchronous and asynchronous mode
    task automatic t_marks;
        seq_in.active = 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            wr(8'h18, 8'h01 << (4 + i));
            lat(i, 8'h01);
            wr(8'h18, 8'h00);
            lat(i, 8'h03);
        end
        rdc(8'h1c, 8'h06, "mark flags");
        wr(8'h1c, 8'h06);
        seq_in.active = 1'b0;
        lat(1, 8'h03);
        rdc(8'h1c, 8'h00, "idle index");
    endtask
    task automatic t_wrap;
        logic ab;
        logic gz;
        ab = 1'b0;
        gz = 1'b0;
        seq_in.active = 1'b1;
        seq_in.fail_active = 1'b1;
        gates_in = '1;
        track_end_in = 1'b1;
        idle(4);
        chk("gates", {4'h0, gates_out}, 8'h0f);
        rdc(8'h1e, 8'h00, "no wrap");
        wr(8'h12, 8'h02);
        repeat (4)
        begin
            @(negedge ref_clk);
            ab |= (seq_abort === 1'b1);
            gz |= (gates_out === 4'h0);
        end
        chk("abort", {7'h0, ab}, 8'h01);
        chk("gates off", {7'h0, gz}, 8'h01);
        track_end_in = 1'b0;
        rdc(8'h1e, 8'h10, "wrap flag");
        rdc(8'h1c, 8'h08, "stop flag");
        chk("err summary", {7'h0, summary_err}, 8'h01);
        wr(8'h1e, 8'h10);
        wr(8'h1c, 8'h08);
        wr(8'h12, 8'h00);
        idle(2);
        chk("err summary", {7'h0, summary_err}, 8'h00);
    endtask
    // an error only counts while the running word has its fail bit
    task automatic t_err;
        seq_in.fail_active = 1'b0;
        seq_in.err_cond = 8'h80;
        idle(3);
        rdc(8'h1e, 8'h00, "no fail");
        seq_in.fail_active = 1'b1;
        idle(3);
        rdc(8'h1e, 8'h80, "fail err");
        seq_in = '0;
        gates_in = '0;
        wr(8'h1e, 8'h80);
        rdc(8'h1e, 8'h00, "err clear");
    endtask
    // buffer side odd parity, disk side odd or even
    task automatic t_par;
        buf_par_in = 1'b1;
        idle(3);
        chk("odd pass", {7'h0, disk_par_out}, 8'h01);
        wr(8'h18, 8'h80);
        idle(3);
        chk("to even", {7'h0, disk_par_out}, 8'h00);
        chk("to odd", {7'h0, buf_par_out}, 8'h01);
        disk_par_in = 1'b1;
        idle(3);
        chk("par error", {7'h0, disk_par_error}, 8'h01);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        idle(10);
        rst_b = 1'b1;
        rdc(8'h14, 8'h00, "x dir rst");
        t_conf();
        t_ports();
        t_events();
        t_marks();
        t_wrap();
        t_err();
        t_par();
        wrap_up();
    end
endmodule // tb_top
`default_nettype wire
